// *** common/scs_pkg.sv ***
package scs_pkg;

  // register indices; the byte address is four times the index
  localparam logic [7:0] TX_IDX       = 8'h29;
  localparam logic [7:0] RX_IDX       = 8'h2A;
  localparam logic [7:0] CTL_IDX      = 8'h2B;
  localparam int         ADDR_W       = 10;
  localparam logic [9:0] TX_ADDR      = {TX_IDX, 2'b00};
  localparam logic [9:0] RX_ADDR      = {RX_IDX, 2'b00};
  localparam logic [9:0] CTL_ADDR     = {CTL_IDX, 2'b00};

  // field positions in serial_control_status
  localparam int         LSB_BIT      = 7;
  localparam int         OVR_BIT      = 6;
  localparam int         CMPLT_BIT    = 5;
  localparam int         TBE_BIT      = 4;
  localparam int         RXF_BIT      = 3;
  localparam int         CPHA_BIT     = 2;
  localparam int         CPOL_BIT     = 1;
  localparam int         EN_BIT       = 0;

  // values after reset, and the count of the last bit of a byte
  localparam logic [7:0] DATA_RST     = 8'h00;
  localparam logic [2:0] BITCNT_RST   = 3'h0;
  localparam logic [2:0] BITCNT_LAST  = 3'h7;

  // configuration bits that software writes
  typedef struct packed {
    logic lsb_first;
    logic cpha;
    logic cpol;
    logic en;
  } scs_cfg_t;

  localparam scs_cfg_t CFG_RST = '{lsb_first: 1'b0, cpha: 1'b0, cpol: 1'b0, en: 1'b0};

  // shifter occupancy
  typedef enum logic [1:0] {
    SH_IDLE   = 2'b01,
    SH_LOADED = 2'b10
  } scs_sh_t;

endpackage

// *** rtl/scs_spi_unit.sv ***
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ns
// Operation
// RULE1: bytes shift out and in msb first when the order bit is 0, lsb first when it is 1.
// RULE2: software leaves order, phase and polarity alone while enabled, but may set them with enable.
// RULE3: overrun sets when a received byte lands while the previous one is unread; a control read clears it.
// RULE4: complete sets once all eight clocks of a byte have passed; a control read clears it. Here it sets at the eighth sample edge, mid-clock in phase 0.
// RULE5: transmit empty reads 1 after reset and while disabled; a transmit write clears it.
// RULE6: the transmit empty event fires only once a written byte has moved into the shifter.
// RULE7: receive full sets when a byte lands in the receive register; a receive read clears it.
// RULE8: phase 0 samples on the leading edge and changes on trailing; phase 1 the other way round.
// RULE9: polarity 0 means the serial clock idles low, polarity 1 that it idles high.
// RULE10: the serial function works only while the enable bit is 1.
// RULE11: a write-only byte register supplies the next byte to send.
// RULE12: a read-only byte register returns the last received byte.
// RULE13: each transfer is eight bits; an idle shifter takes a waiting byte.
module scs_spi_unit
  import scs_pkg::*;
(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // serial link, partner drives the clock
  input  wire logic              spi_sclk,
  input  wire logic              spi_ss_n,
  input  wire logic              spi_mosi,
  output logic                   spi_miso,
  output logic                   spi_miso_oe,
  // transmit empty event level
  output logic                   tx_empty_event
);

  logic [31:0] readdata_reg;
  logic        wait_reg;
  scs_cfg_t    cfg_reg;
  logic        ovr_reg, cmplt_reg, tbe_reg, rxf_reg, armed_reg;
  logic [7:0]  tx_buf_reg, rx_buf_reg, tx_sh_reg, rx_sh_reg;
  logic [2:0]  bitcnt_reg;
  scs_sh_t     sh_reg;
  logic        sclk_meta, sclk_sync, sclk_prev;
  logic        ss_meta, ss_sync, mosi_meta, mosi_sync;
  logic        miso_reg, miso_oe_reg;

  // bus decode; an access takes effect at the edge where waitrequest is seen low
  logic acc, rd_ctl, rd_rx, wr_ctl, wr_tx;
  assign acc    = (avs_read | avs_write) & ~wait_reg;
  assign rd_ctl = acc & avs_read & (avs_address == CTL_ADDR);
  assign rd_rx  = acc & avs_read & (avs_address == RX_ADDR);
  assign wr_ctl = acc & avs_write & (avs_address == CTL_ADDR) & avs_byteenable[0];
  assign wr_tx  = acc & avs_write & (avs_address == TX_ADDR) & avs_byteenable[0];

  // one wait cycle per access; read data is captured in it
  always_ff @(posedge clock) begin
    if (rst) begin
      wait_reg <= 1'b1;
    end else begin
      wait_reg <= ~((avs_read | avs_write) & wait_reg);
    end
  end

  // unmapped and write-only addresses read as zero
  always_ff @(posedge clock) begin
    if (rst) begin
      readdata_reg <= 32'h0000_0000;
    end else if (avs_read & wait_reg) begin
      readdata_reg <= 32'h0000_0000;
      if (avs_address == CTL_ADDR) begin
        readdata_reg[7:0] <= {cfg_reg.lsb_first, ovr_reg, cmplt_reg, tbe_reg,
                              rxf_reg, cfg_reg.cpha, cfg_reg.cpol, cfg_reg.en};
      end else if (avs_address == RX_ADDR) begin
        // RULE12: last received byte
        readdata_reg[7:0] <= rx_buf_reg;
      end
    end
  end

  // configuration; the block trusts software not to change mode bits while enabled
  // RULE2: mode written with enable
  always_ff @(posedge clock) begin
    if (rst) begin
      cfg_reg <= CFG_RST;
    end else if (wr_ctl) begin
      cfg_reg <= '{lsb_first: avs_writedata[LSB_BIT], cpha: avs_writedata[CPHA_BIT],
                   cpol: avs_writedata[CPOL_BIT], en: avs_writedata[EN_BIT]};
    end
  end

  // two-flop synchronisers for the pins
  always_ff @(posedge clock) begin
    if (rst) begin
      sclk_meta <= 1'b0;
      sclk_sync <= 1'b0;
      sclk_prev <= 1'b0;
      ss_meta   <= 1'b1;
      ss_sync   <= 1'b1;
      mosi_meta <= 1'b0;
      mosi_sync <= 1'b0;
    end else begin
      sclk_meta <= spi_sclk;
      sclk_sync <= sclk_meta;
      sclk_prev <= sclk_sync;
      ss_meta   <= spi_ss_n;
      ss_sync   <= ss_meta;
      mosi_meta <= spi_mosi;
      mosi_sync <= mosi_meta;
    end
  end

  // edge roles follow polarity and phase
  logic active, lead, trail, sample, change, byte_done, load, out_bit;
  logic [7:0] rx_new;
  assign active = cfg_reg.en & ~ss_sync;
  // RULE9: leading edge leaves the idle level
  assign lead   = (sclk_prev == cfg_reg.cpol) & (sclk_sync != cfg_reg.cpol);
  assign trail  = (sclk_prev != cfg_reg.cpol) & (sclk_sync == cfg_reg.cpol);
  // RULE8: sample and change edges
  assign sample = active & (cfg_reg.cpha ? trail : lead);
  assign change = active & (cfg_reg.cpha ? lead : trail);
  // RULE13: eighth sample closes the byte
  assign byte_done = sample & (bitcnt_reg == BITCNT_LAST);
  // RULE1: order of the incoming bits
  assign rx_new  = cfg_reg.lsb_first ? {mosi_sync, rx_sh_reg[7:1]} : {rx_sh_reg[6:0], mosi_sync};
  assign out_bit = cfg_reg.lsb_first ? tx_sh_reg[0] : tx_sh_reg[7];
  // RULE13: idle shifter takes a waiting byte between bytes only
  assign load    = cfg_reg.en & (sh_reg == SH_IDLE) & ~tbe_reg & (bitcnt_reg == BITCNT_RST);

  // bit counter; a deselect mid-byte drops the partial byte
  always_ff @(posedge clock) begin
    if (rst | ~active) begin
      bitcnt_reg <= BITCNT_RST;
    end else if (sample) begin
      bitcnt_reg <= bitcnt_reg + 3'h1;
    end
  end

  // shifter occupancy
  always_ff @(posedge clock) begin
    if (rst | ~cfg_reg.en) begin
      sh_reg <= SH_IDLE;
    end else begin
      unique case (sh_reg)
        SH_IDLE:   if (load) begin
          sh_reg <= SH_LOADED;
        end
        SH_LOADED: if (byte_done) begin
          sh_reg <= SH_IDLE;
        end
      endcase
    end
  end

  // transmit shifter; a change edge at count zero keeps the bit in place, the first of a byte in phase 1 and the last in phase 0
  always_ff @(posedge clock) begin
    if (rst | ~cfg_reg.en) begin
      tx_sh_reg <= DATA_RST;
    end else if (load) begin
      tx_sh_reg <= tx_buf_reg;
    end else if (change & (bitcnt_reg != BITCNT_RST)) begin
      // RULE1: order of the outgoing bits
      tx_sh_reg <= cfg_reg.lsb_first ? {1'b0, tx_sh_reg[7:1]} : {tx_sh_reg[6:0], 1'b0};
    end
  end

  // receive shifter and buffer
  always_ff @(posedge clock) begin
    if (rst) begin
      rx_sh_reg  <= DATA_RST;
      rx_buf_reg <= DATA_RST;
    end else if (sample) begin
      rx_sh_reg <= rx_new;
      if (byte_done) begin
        rx_buf_reg <= rx_new;
      end
    end
  end

  // transmit buffer
  // RULE11: write-only transmit register
  always_ff @(posedge clock) begin
    if (rst) begin
      tx_buf_reg <= DATA_RST;
    end else if (wr_tx & cfg_reg.en) begin
      tx_buf_reg <= avs_writedata[7:0];
    end
  end

  // status flags; set beats clear, and a control read clears only the bits it returned
  always_ff @(posedge clock) begin
    if (rst) begin
      ovr_reg   <= 1'b0;
      cmplt_reg <= 1'b0;
      rxf_reg   <= 1'b0;
    end else begin
      // RULE3: overrun on unread receive byte
      ovr_reg   <= (byte_done & rxf_reg) | (ovr_reg & ~(rd_ctl & readdata_reg[OVR_BIT]));
      // RULE4: completion at the eighth sample edge, which ends the last clock in phase 1 only
      cmplt_reg <= byte_done | (cmplt_reg & ~(rd_ctl & readdata_reg[CMPLT_BIT]));
      // RULE7: receive full set and cleared
      rxf_reg   <= byte_done | (rxf_reg & ~rd_rx);
    end
  end

  // transmit empty flag and its event
  always_ff @(posedge clock) begin
    if (rst | ~cfg_reg.en) begin
      // RULE5: empty while disabled
      tbe_reg   <= 1'b1;
      armed_reg <= 1'b0;
    end else begin
      // RULE5: transmit write clears empty
      // a write on the load edge leaves its new byte waiting, so the write wins there
      tbe_reg   <= (load | tbe_reg) & ~wr_tx;
      // RULE6: event only after a byte reached the shifter
      armed_reg <= (load | armed_reg) & ~wr_tx;
    end
  end

  // output pin drive, registered; quiet while disabled or deselected
  // RULE10: serial side inactive when disabled
  always_ff @(posedge clock) begin
    if (rst) begin
      miso_reg    <= 1'b0;
      miso_oe_reg <= 1'b0;
    end else begin
      miso_reg    <= active & out_bit;
      miso_oe_reg <= active;
    end
  end

  assign avs_readdata    = readdata_reg;
  assign avs_waitrequest = wait_reg;
  assign spi_miso        = miso_reg;
  assign spi_miso_oe     = miso_oe_reg;
  assign tx_empty_event  = armed_reg;

  a_order_bit: assert property (@(posedge clock) disable iff (rst) // RULE1
    active |=> spi_miso == (cfg_reg.lsb_first ? $past(tx_sh_reg[0]) : $past(tx_sh_reg[7])))
    else $error("miso does not follow bit order");
  a_ovr_set: assert property (@(posedge clock) disable iff (rst) // RULE3
    (byte_done & rxf_reg) |=> ovr_reg)
    else $error("overrun not set");
  a_cmplt_set: assert property (@(posedge clock) disable iff (rst) // RULE4
    byte_done |=> cmplt_reg ##1 (cmplt_reg | $past(rd_ctl)))
    else $error("complete not set or lost");
  a_tbe_disabled: assert property (@(posedge clock) disable iff (rst) // RULE5
    ~cfg_reg.en |=> tbe_reg)
    else $error("tx empty low while disabled");
  a_tbe_write: assert property (@(posedge clock) disable iff (rst) // RULE5
    (wr_tx & cfg_reg.en & ~wr_ctl) |=> ~tbe_reg)
    else $error("tx write did not clear empty");
  a_event_gate: assert property (@(posedge clock) disable iff (rst) // RULE6
    tx_empty_event |-> tbe_reg)
    else $error("event without empty buffer");
  a_rxf_set: assert property (@(posedge clock) disable iff (rst) // RULE7
    byte_done |=> rxf_reg && rx_buf_reg == $past(rx_new))
    else $error("receive full or data wrong");
  a_sample_edge: assert property (@(posedge clock) disable iff (rst) // RULE8
    sample |-> ($past(sclk_sync) != sclk_sync) && (sclk_sync == (cfg_reg.cpha ~^ cfg_reg.cpol)))
    else $error("sample on wrong edge");
  a_quiet_off: assert property (@(posedge clock) disable iff (rst) // RULE10
    ~cfg_reg.en |=> ~spi_miso_oe ##1 (~spi_miso_oe | $past(cfg_reg.en)))
    else $error("miso driven while disabled");
  a_load_byte: assert property (@(posedge clock) disable iff (rst) // RULE13
    (load & ~wr_ctl) |=> sh_reg == SH_LOADED && tbe_reg == !$past(wr_tx) && tx_sh_reg == $past(tx_buf_reg))
    else $error("shifter did not take waiting byte");

endmodule

// *** test/scs_master_model.sv ***
`timescale 1ns/1ns
module scs_master_model (
  // serial link, the model owns the clock and select
  output logic      spi_sclk,
  output logic      spi_ss_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  // idle link before the first frame
  initial begin
    spi_sclk = 1'b0;
    spi_ss_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // one byte frame, 800 ns clock; the clock stands still between frames
  task automatic xfer(input logic cpol, input logic cpha, input logic lsb,
                      input logic [7:0] tx, output logic [7:0] rx);
    int b;
    #37 spi_sclk = cpol;
    #800 spi_ss_n = 1'b0;
    for (int i = 0; i < 8; i++) begin
      b = lsb ? i : 7 - i;
      if (!cpha) spi_mosi = tx[b];
      #400 spi_sclk = ~cpol;
      if (cpha) spi_mosi = tx[b];
      else rx[b] = spi_miso;
      #400 spi_sclk = cpol;
      if (cpha) rx[b] = spi_miso;
    end
    #400 spi_ss_n = 1'b1;
    // released data line must not look like a held bit
    spi_mosi = ~spi_mosi;
  endtask
endmodule

// *** test/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  import scs_pkg::*;
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = 32'h0;
  logic [3:0]        avs_byteenable = 4'h1;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              spi_sclk;
  logic              spi_ss_n;
  logic              spi_mosi;
  logic              spi_miso;
  logic              spi_miso_oe;
  logic              tx_empty_event;
  int                err_total = 0;
  int                n_tests = 0;
  int                cyc = 0;
  logic [31:0]       seed = 32'h836EED2B;

  always #50 clock = ~clock;

  scs_spi_unit dut_u (.clock(clock), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .spi_sclk(spi_sclk),
    .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .tx_empty_event(tx_empty_event));
  // released data-out line floats up to its pull-up level
  logic              miso_line;
  assign miso_line = spi_miso_oe ? spi_miso : 1'b1;
  scs_master_model m_u (.spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi), .spi_miso(miso_line));

  // xorshift keeps the run repeatable
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // expected control byte from {order,phase,polarity,enable} and {ovr,cmp,tbe,rxf}
  function automatic logic [7:0] ctl(input logic [3:0] cfg, input logic [3:0] st);
    return {cfg[3], st, cfg[2:0]};
  endfunction

  // one avalon access; held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clock);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h0, wd};
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic s);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("FAIL %s expected %b seen %b", nm, e, s);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdc(input logic [9:0] a, input logic [7:0] e, input string nm);
    logic [7:0] x;
    bus(1'b0, a, 8'h00, x);
    chk8(nm, e, x);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard, far above the roughly 1200 cycles the run needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    logic [7:0] mr;
    logic [7:0] tx;
    logic [7:0] mx;
    logic [3:0] cfg;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    // reset state and refused accesses
    rdc(CTL_ADDR, 8'h10, "ctl_reset");
    chk1("event_reset", 1'b0, tx_empty_event);
    wr(RX_ADDR, 8'hA5);
    rdc(RX_ADDR, 8'h00, "rx_readonly");
    rdc(TX_ADDR, 8'h00, "tx_writeonly");
    rdc(10'h3FC, 8'h00, "unmapped");
    wr(TX_ADDR, 8'h3C);
    rdc(CTL_ADDR, 8'h10, "tx_while_off");
    $display("test reset done");
    // all four modes in both bit orders; disable before every change of setting
    for (int m = 0; m < 8; m++) begin
      cfg = {m[2:0], 1'b1};
      tx = 8'(rnd());
      mx = 8'(rnd());
      wr(CTL_ADDR, 8'h00);
      wr(CTL_ADDR, ctl(cfg, 4'h0));
      wr(TX_ADDR, tx);
      repeat (4) @(posedge clock);
      chk1("event_loaded", 1'b1, tx_empty_event);
      m_u.xfer(cfg[1], cfg[2], cfg[3], mx, mr);
      repeat (8) @(posedge clock);
      chk8("miso_byte", tx, mr);
      rdc(CTL_ADDR, ctl(cfg, 4'b0111), "ctl_done");
      rdc(RX_ADDR, mx, "rx_byte");
      rdc(CTL_ADDR, ctl(cfg, 4'b0010), "ctl_cleared");
    end
    $display("test modes done");
    // second byte lands while the first is unread
    wr(CTL_ADDR, 8'h00);
    wr(CTL_ADDR, 8'h01);
    wr(TX_ADDR, 8'h81);
    m_u.xfer(1'b0, 1'b0, 1'b0, 8'h5A, mr);
    wr(TX_ADDR, 8'h18);
    m_u.xfer(1'b0, 1'b0, 1'b0, 8'hC3, mr);
    repeat (8) @(posedge clock);
    chk8("second_miso", 8'h18, mr);
    rdc(CTL_ADDR, 8'h79, "ctl_overrun");
    rdc(CTL_ADDR, 8'h19, "ovr_cleared");
    rdc(RX_ADDR, 8'hC3, "rx_newest");
    $display("test overrun done");
    // disabled block neither shifts nor flags
    wr(CTL_ADDR, 8'h00);
    repeat (2) @(posedge clock);
    chk1("event_off", 1'b0, tx_empty_event);
    m_u.xfer(1'b0, 1'b0, 1'b0, 8'hE7, mr);
    repeat (8) @(posedge clock);
    chk8("miso_off", 8'hFF, mr);
    rdc(CTL_ADDR, 8'h10, "ctl_off");
    $display("test disabled done");
    finish_test();
  end
endmodule
